// File: shared/ppacc_pkg.sv
// Purpose: shared constants and types for the prescale, alignment and pairing control block
// Assumes: 32-bit AXI4-Lite register access, one register per aligned word
// Notes:   register byte address is four times the register index
package ppacc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W            = 8;
    localparam int unsigned IDX_PRESCALE      = 3;
    localparam int unsigned IDX_CENTER        = 4;
    localparam int unsigned IDX_PAIRING       = 5;
    localparam logic [7:0]  ADDR_PRESCALE     = 8'(IDX_PRESCALE * 4);
    localparam logic [7:0]  ADDR_CENTER       = 8'(IDX_CENTER * 4);
    localparam logic [7:0]  ADDR_PAIRING      = 8'(IDX_PAIRING * 4);

    // ------------------------------------------------------------------
    // field positions and implemented-bit masks
    // ------------------------------------------------------------------
    localparam int unsigned CLK_A_SEL_LSB     = 0;
    localparam int unsigned CLK_B_SEL_LSB     = 4;
    localparam int unsigned FREEZE_STOP_BIT   = 2;
    localparam int unsigned WAIT_STOP_BIT     = 3;
    localparam int unsigned PAIR_CH0_CH1_BIT  = 4;
    localparam int unsigned PAIR_CH2_CH3_BIT  = 5;
    localparam int unsigned PAIR_CH4_CH5_BIT  = 6;
    localparam logic [7:0]  PRESCALE_MASK     = 8'h77;
    localparam logic [7:0]  CENTER_MASK       = 8'h3F;
    localparam logic [7:0]  PAIRING_MASK      = 8'h7C;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  PRESCALE_RESET    = 8'h00;
    localparam logic [7:0]  CENTER_RESET      = 8'h00;
    localparam logic [7:0]  PAIRING_RESET     = 8'h00;

    // ------------------------------------------------------------------
    // sizes and bus answers
    // ------------------------------------------------------------------
    localparam int unsigned NUM_CH            = 6;
    localparam int unsigned DIV_SEL_W         = 3;
    localparam int unsigned DIV_CNT_W         = 7;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    // effective per-channel configuration handed to the channel logic
    typedef struct packed {
        logic [5:0] time_base_tick;
        logic [5:0] out_enable;
        logic [5:0] center_align;
        logic [5:0] start_high;
        logic [5:0] high_byte;
    } ppacc_chan_cfg_s;

endpackage

// File: rtl/ppacc_prescaler.sv
// Purpose: shared divide chain giving clock A and clock B enable ticks
// Assumes: one free-running counter serves both taps
// Notes:   a select change acts on the very next tick decision
`timescale 1ns/1ps
module ppacc_prescaler #(
    parameter int unsigned CNT_W = ppacc_pkg::DIV_CNT_W
) (
    // clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            reset_n,
    // control
    input  wire logic                            run,
    input  wire logic [ppacc_pkg::DIV_SEL_W-1:0] sel_a,
    input  wire logic [ppacc_pkg::DIV_SEL_W-1:0] sel_b,
    // ticks
    output logic                                 tick_a,
    output logic                                 tick_b
);
    import ppacc_pkg::*;

    logic [CNT_W-1:0] div_cnt;

    // tick when the low sel bits of the count are all ones
    function automatic logic tap_due(input logic [CNT_W-1:0] cnt,
                                     input logic [DIV_SEL_W-1:0] sel);
        logic [CNT_W-1:0] low_mask;
        low_mask = CNT_W'((1 << sel) - 1);
        return &(cnt | ~low_mask);
    endfunction

    // counter holds while the input clock is gated
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= '0;
        end else if (run) begin
            div_cnt <= div_cnt + CNT_W'(1);
        end
    end

    assign tick_a = run & tap_due(div_cnt, sel_a);
    assign tick_b = run & tap_due(div_cnt, sel_b);

endmodule

// File: rtl/ppacc_ctrl.sv
// Purpose: prescale select, alignment and channel pairing registers behind AXI4-Lite
// Assumes: scaled clocks and channel enable/polarity/clock-select come from sibling logic
// Notes:   wait and freeze levels are pins and pass a two-stage synchroniser
//
// What this block does
// - clock A is bus clock divided by 1..128 from a 3-bit select field.
// - clock B has its own 3-bit select, same mapping, independent of A.
// - clock A and its scaled form feed only channels 0, 1, 4 and 5.
// - clock B and its scaled form feed only channels 2 and 3.
// - prescale selects are writable anytime and act at once, unsynchronised.
// - six alignment bits, bit n belongs to channel n.
// - alignment bit one gives center alignment, zero gives left alignment.
// - bits 6, 5, 4 merge pairs 4/5, 2/3, 0/1 into 16-bit channels.
// - in a merged pair the even channel holds the high-order byte.
// - merged waveform leaves on the odd output, odd channel controls govern.
// - wait-stop bit set gates the prescaler input clock during wait mode.
// - freeze-stop bit set gates the prescaler input clock during freeze mode.
// - registers stay accessible while frozen; counting resumes on bit clear or exit.
// - all three registers are readable and writable at any time.
// - channel clock-select picks unscaled or scaled clock of its group.
// - a merged even channel has its enable ignored and its output disabled.
// - polarity one starts the cycle high, polarity zero starts low.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module ppacc_ctrl
    import ppacc_pkg::*;
(
    // clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         reset_n,
    // axi4-lite write address
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [ppacc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                   s_axi_awprot,
    // axi4-lite write data
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    // axi4-lite write response
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    output logic [1:0]                        s_axi_bresp,
    // axi4-lite read address
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    input  wire logic [ppacc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                   s_axi_arprot,
    // axi4-lite read data
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    // processor mode pins
    input  wire logic                         wait_mode_pin,
    input  wire logic                         freeze_mode_pin,
    // sibling channel controls and scaled clocks
    input  wire logic [5:0]                   channel_enable_bit,
    input  wire logic [5:0]                   channel_polarity_bit,
    input  wire logic [5:0]                   channel_clock_select_bit,
    input  wire logic                         scaled_a_tick,
    input  wire logic                         scaled_b_tick,
    // time base and channel configuration
    output logic                              clk_a_tick,
    output logic                              clk_b_tick,
    output logic                              prescaler_running,
    output ppacc_pkg::ppacc_chan_cfg_s        chan_cfg
);
    import ppacc_pkg::*;

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] prescale_clock_select;
    logic [7:0] center_align_enable;
    logic [7:0] channel_pairing_control;

    // ------------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------------
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr_q;
    logic              w_full;
    logic [7:0]        w_byte_q;
    logic              w_lane0_q;
    logic              next_aw_full;
    logic              next_w_full;
    logic              next_bvalid;
    logic              next_rvalid;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // register read value, zero for reserved bits and unmapped words
    function automatic logic [7:0] reg_value(input logic [ADDR_W-1:0] addr,
                                             input logic [7:0] pre,
                                             input logic [7:0] cae,
                                             input logic [7:0] ctl);
        logic [7:0] val;
        val = 8'h00;
        case (addr)
            ADDR_PRESCALE: val = pre & PRESCALE_MASK;
            ADDR_CENTER:   val = cae & CENTER_MASK;
            ADDR_PAIRING:  val = ctl & PAIRING_MASK;
            default:       val = 8'h00;
        endcase
        return val;
    endfunction

    // true for one of the three mapped words
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        return (addr == ADDR_PRESCALE) || (addr == ADDR_CENTER) || (addr == ADDR_PAIRING);
    endfunction

    // odd partner value of a channel field when its pair is merged
    function automatic logic [5:0] govern_by_odd(input logic [5:0] bits,
                                                 input logic [2:0] pair_on);
        logic [5:0] res;
        res = bits;
        for (int p = 0; p < 3; p++) begin
            if (pair_on[p]) begin
                res[2*p] = bits[2*p+1];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // write channel handshakes
    // ------------------------------------------------------------------
    wire aw_hs      = s_axi_awvalid & s_axi_awready;
    wire w_hs       = s_axi_wvalid & s_axi_wready;
    wire do_write   = aw_full & w_full & ~s_axi_bvalid;
    wire write_ok   = addr_mapped(aw_addr_q);
    wire b_done     = s_axi_bvalid & s_axi_bready;
    wire ar_hs      = s_axi_arvalid & s_axi_arready;
    wire r_done     = s_axi_rvalid & s_axi_rready;
    wire lane_write = do_write & w_lane0_q;
    wire wr_pre     = lane_write & (aw_addr_q == ADDR_PRESCALE);
    wire wr_cae     = lane_write & (aw_addr_q == ADDR_CENTER);
    wire wr_ctl     = lane_write & (aw_addr_q == ADDR_PAIRING);

    // next-state of the handshake holders
    assign next_aw_full = (aw_full | aw_hs) & ~do_write;
    assign next_w_full  = (w_full | w_hs) & ~do_write;
    assign next_bvalid  = do_write | (s_axi_bvalid & ~b_done);
    assign next_rvalid  = ar_hs | (s_axi_rvalid & ~r_done);

    // address and data holders, taken in either order
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_full   <= 1'b0;
            aw_addr_q <= '0;
            w_full    <= 1'b0;
            w_byte_q  <= 8'h00;
            w_lane0_q <= 1'b0;
        end else begin
            aw_full <= next_aw_full;
            w_full  <= next_w_full;
            if (aw_hs) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_byte_q  <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
            end
        end
    end

    // ready and response flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= ~next_aw_full & ~next_bvalid;
            s_axi_wready  <= ~next_w_full & ~next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (do_write) begin
                s_axi_bresp <= write_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // read channel, answered on the same edge that takes the address
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_hs) begin
                s_axi_rdata <= {24'h00_0000, reg_value(s_axi_araddr, prescale_clock_select,
                                                        center_align_enable,
                                                        channel_pairing_control)};
                s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration registers, writable at any moment
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale_clock_select   <= PRESCALE_RESET;
            center_align_enable     <= CENTER_RESET;
            channel_pairing_control <= PAIRING_RESET;
        end else begin
            if (wr_pre) begin
                prescale_clock_select <= w_byte_q & PRESCALE_MASK;
            end
            if (wr_cae) begin
                center_align_enable <= w_byte_q & CENTER_MASK;
            end
            if (wr_ctl) begin
                channel_pairing_control <= w_byte_q & PAIRING_MASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // field views
    // ------------------------------------------------------------------
    wire [DIV_SEL_W-1:0] clk_a_divider_sel = prescale_clock_select[CLK_A_SEL_LSB +: DIV_SEL_W];
    wire [DIV_SEL_W-1:0] clk_b_divider_sel = prescale_clock_select[CLK_B_SEL_LSB +: DIV_SEL_W];
    wire [5:0] center_align_bit  = center_align_enable[5:0];
    wire       pair_ch0_ch1      = channel_pairing_control[PAIR_CH0_CH1_BIT];
    wire       pair_ch2_ch3      = channel_pairing_control[PAIR_CH2_CH3_BIT];
    wire       pair_ch4_ch5      = channel_pairing_control[PAIR_CH4_CH5_BIT];
    wire       wait_clock_stop   = channel_pairing_control[WAIT_STOP_BIT];
    wire       freeze_clock_stop = channel_pairing_control[FREEZE_STOP_BIT];
    wire [2:0] pair_on           = {pair_ch4_ch5, pair_ch2_ch3, pair_ch0_ch1};

    // ------------------------------------------------------------------
    // mode pin synchronisers
    // ------------------------------------------------------------------
    logic wait_meta;
    logic wait_sync;
    logic freeze_meta;
    logic freeze_sync;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_meta   <= 1'b0;
            wait_sync   <= 1'b0;
            freeze_meta <= 1'b0;
            freeze_sync <= 1'b0;
        end else begin
            wait_meta   <= wait_mode_pin;
            wait_sync   <= wait_meta;
            freeze_meta <= freeze_mode_pin;
            freeze_sync <= freeze_meta;
        end
    end

    // prescaler input clock gate
    wire gate_wait   = wait_sync & wait_clock_stop;
    wire gate_freeze = freeze_sync & freeze_clock_stop;
    wire presc_run   = ~gate_wait & ~gate_freeze;

    // ------------------------------------------------------------------
    // divide chain
    // ------------------------------------------------------------------
    logic raw_tick_a;
    logic raw_tick_b;

    ppacc_prescaler #(
        .CNT_W (DIV_CNT_W)
    ) u_prescaler (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .run      (presc_run),
        .sel_a    (clk_a_divider_sel),
        .sel_b    (clk_b_divider_sel),
        .tick_a   (raw_tick_a),
        .tick_b   (raw_tick_b)
    );

    // ------------------------------------------------------------------
    // per-channel effective settings
    // ------------------------------------------------------------------
    wire [5:0] eff_clk_sel  = govern_by_odd(channel_clock_select_bit, pair_on);
    wire [5:0] eff_polarity = govern_by_odd(channel_polarity_bit, pair_on);
    wire [5:0] eff_center   = govern_by_odd(center_align_bit, pair_on);
    wire [5:0] even_off     = {1'b0, pair_on[2], 1'b0, pair_on[1], 1'b0, pair_on[0]};
    wire [5:0] eff_enable   = govern_by_odd(channel_enable_bit, pair_on) & ~even_off;
    wire [5:0] high_byte    = even_off;
    wire [5:0] group_plain  = {raw_tick_a, raw_tick_a, raw_tick_b, raw_tick_b,
                               raw_tick_a, raw_tick_a};
    wire [5:0] group_scaled = {scaled_a_tick, scaled_a_tick, scaled_b_tick, scaled_b_tick,
                               scaled_a_tick, scaled_a_tick};
    wire [5:0] base_tick    = (eff_clk_sel & group_scaled) | (~eff_clk_sel & group_plain);

    // output flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_a_tick        <= 1'b0;
            clk_b_tick        <= 1'b0;
            prescaler_running <= 1'b0;
            chan_cfg          <= '0;
        end else begin
            clk_a_tick                <= raw_tick_a;
            clk_b_tick                <= raw_tick_b;
            prescaler_running         <= presc_run;
            chan_cfg.time_base_tick   <= base_tick;
            chan_cfg.out_enable       <= eff_enable;
            chan_cfg.center_align     <= eff_center;
            chan_cfg.start_high       <= eff_polarity;
            chan_cfg.high_byte        <= high_byte;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    undivided_a_tick_a : assert property (
        $past(reset_n) && $past(presc_run) && $past(clk_a_divider_sel) == 3'h0 |-> clk_a_tick)
        else $error("clock A not ticking every cycle when undivided");

    div2_b_spacing_a : assert property (
        clk_b_tick && presc_run && clk_b_divider_sel == 3'h1 && $stable(clk_b_divider_sel)
        |=> !clk_b_tick)
        else $error("clock B ticked twice in a row at divide by two");

    ch2_uses_b_a : assert property (
        $past(reset_n) && !$past(eff_clk_sel[2])
        |-> chan_cfg.time_base_tick[2] == $past(raw_tick_b))
        else $error("channel 2 time base not taken from clock B");

    ch4_uses_sa_a : assert property (
        $past(reset_n) && $past(eff_clk_sel[4])
        |-> chan_cfg.time_base_tick[4] == $past(scaled_a_tick))
        else $error("channel 4 time base not taken from scaled clock A");

    prescale_write_a : assert property (
        wr_pre |=> prescale_clock_select == ($past(w_byte_q) & PRESCALE_MASK))
        else $error("prescale write not applied on the next edge");

    center_follow_a : assert property (
        !pair_ch2_ch3 && $stable(center_align_enable)
        |=> chan_cfg.center_align[3:2] == $past(center_align_enable[3:2]))
        else $error("alignment output does not follow its bit");

    merged_even_off_a : assert property (
        pair_ch0_ch1 |=> !chan_cfg.out_enable[0] && chan_cfg.high_byte[0])
        else $error("merged even channel output still enabled");

    odd_polarity_a : assert property (
        pair_ch4_ch5 |=> chan_cfg.start_high[4] == $past(channel_polarity_bit[5]))
        else $error("merged pair polarity not taken from odd channel");

    wait_gate_a : assert property (
        wait_clock_stop && wait_mode_pin [*3] |=> !prescaler_running ##0 !clk_a_tick)
        else $error("prescaler still running in wait mode with stop bit set");

    freeze_access_a : assert property (
        freeze_sync && ar_hs |=> s_axi_rvalid ##0 s_axi_rresp == RESP_OKAY
        || !addr_mapped($past(s_axi_araddr)))
        else $error("register read refused while frozen");

    write_answer_a : assert property (
        aw_full && w_full && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write response missing one edge after address and data");

endmodule

// File: tb/tb.sv
// Purpose: self-checking bench for the prescale, alignment and pairing control block
// Assumes: AXI4-Lite tasks, 10 MHz core clock, byte registers in wdata[7:0]
// Notes:   prot, strobe and scaled B tick held fixed; scaled A tick toggles
`timescale 1ns/1ps
module tb;
    import ppacc_pkg::*;
    logic core_clk = 0, reset_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic wt = 0, fz = 0, sa = 0, awready, wready, bvalid, arready, rvalid, ta, tb_t, run;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdata;
    logic [1:0] bresp, rresp;
    logic [5:0] en = 6'h00, pol = 6'h2A, cks = 6'h14;
    ppacc_chan_cfg_s cfg;
    int bad_count = 0, num_checks = 0, cyc = 0;
    logic [7:0] adr [3] = '{ADDR_PRESCALE, ADDR_CENTER, ADDR_PAIRING};
    logic [7:0] msk [3] = '{PRESCALE_MASK, CENTER_MASK, PAIRING_MASK};
    // ------------------------------------------------------------------
    // design and clock
    // ------------------------------------------------------------------
    ppacc_ctrl ppacc_ctrl_i (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_bvalid(bvalid),
        .s_axi_bready(bre), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rre),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .wait_mode_pin(wt), .freeze_mode_pin(fz),
        .channel_enable_bit(en), .channel_polarity_bit(pol), .channel_clock_select_bit(cks),
        .scaled_a_tick(sa), .scaled_b_tick(1'b0), .clk_a_tick(ta), .clk_b_tick(tb_t),
        .prescaler_running(run), .chan_cfg(cfg));
    always #50 core_clk = ~core_clk;
    // scaled clock A pulses every other cycle
    always @(posedge core_clk) sa <= ~sa;
    // cut a hang short
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // write with response check
    task automatic wc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ad, dd;
        ad = 0;
        dd = 0;
        awa <= a; wd <= {24'h0, d}; awv <= 1; wv <= 1; bre <= 1;
        while (!(ad && dd)) begin
            @(posedge core_clk);
            if (awv && awready) begin ad = 1; awv <= 0; end
            if (wv && wready) begin dd = 1; wv <= 0; end
        end
        do @(posedge core_clk); while (!bvalid);
        bre <= 0;
        chk(bresp, er);
    endtask
    // read with data and response check
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        ara <= a; arv <= 1; rre <= 1;
        do @(posedge core_clk); while (!(arv && arready));
        arv <= 0;
        do @(posedge core_clk); while (!rvalid);
        rre <= 0;
        chk(rdata, e);
        chk(rresp, er);
    endtask
    task automatic ticks(input int n, input logic [31:0] ea, input logic [31:0] eb);
        logic [31:0] ca, cb;
        ca = 0;
        cb = 0;
        repeat (n) begin @(posedge core_clk); ca += ta; cb += tb_t; end
        chk(ca, ea);
        chk(cb, eb);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge core_clk);
        reset_n <= 1;
        @(posedge core_clk);
        for (int i = 0; i < 3; i++) begin
            rc(adr[i], 32'h0000_0000, RESP_OKAY);
            wc(adr[i], 8'hFF, RESP_OKAY);
            rc(adr[i], {24'h0, msk[i]}, RESP_OKAY);
        end
        wc(8'h18, 8'hFF, RESP_SLVERR);
        rc(8'h18, 32'h0000_0000, RESP_SLVERR);
        wc(ADDR_CENTER, 8'h2A, RESP_OKAY);
        wc(ADDR_PAIRING, 8'h70, RESP_OKAY);
        wc(ADDR_PRESCALE, 8'h00, RESP_OKAY);
        en <= 6'h3F;
        repeat (3) @(posedge core_clk);
        chk({cfg.time_base_tick[3:2], cfg.out_enable, cfg.center_align, cfg.start_high,
             cfg.high_byte}, {2'b11, 6'h2A, 6'h3F, 6'h3F, 6'h15});
        en <= 6'h00;
        wc(ADDR_PAIRING, 8'h00, RESP_OKAY);
        en <= 6'h3F;
        for (int k = 0; k < 8; k++) begin
            wc(ADDR_PRESCALE, {1'b0, 3'(7 - k), 1'b0, 3'(k)}, RESP_OKAY);
            ticks(128, 128 >> k, 128 >> (7 - k));
        end
        chk({cfg.time_base_tick[3:2], cfg.out_enable, cfg.center_align, cfg.start_high,
             cfg.high_byte}, {2'b10, 6'h3F, 6'h2A, 6'h2A, 6'h00});
        wc(ADDR_PAIRING, 8'h04, RESP_OKAY);
        fz <= 1;
        repeat (5) @(posedge core_clk);
        chk(run, 1'b0);
        rc(ADDR_PAIRING, 32'h0000_0004, RESP_OKAY);
        ticks(16, 0, 0);
        wc(ADDR_PAIRING, 8'h00, RESP_OKAY);
        wt <= 1;
        ticks(128, 1, 128);
        wc(ADDR_PAIRING, 8'h08, RESP_OKAY);
        repeat (5) @(posedge core_clk);
        chk(run, 1'b0);
        wt <= 0;
        repeat (5) @(posedge core_clk);
        chk(run, 1'b1);
        report_and_stop();
    end
endmodule
